// *** bench/core_model.sv ***
// Core-side partner: instruction boundaries, returns and taken vectors
`timescale 1ns/1ps
module core_model
   import intc_pkg::*;
(
   input wire logic clk_i,
   input wire logic slow_i,
   input wire logic ret_i,
   input wire core_req_type core_i,
   output logic boundary_o,
   output logic ret_o,
   output int takes_o
);
   // One process owns each value; outputs only mirror them
   logic bnd_q = 1'b0;
   logic ret_q = 1'b0;
   int take_cnt = 0;

   // Slow mode offers a boundary every other cycle, like two-cycle instructions
   always @(posedge clk_i) begin
      bnd_q <= slow_i ? ~bnd_q : 1'b1;
      ret_q <= ret_i;
      if (core_i.take === 1'b1) begin
         take_cnt <= take_cnt + 1;
      end
   end

   assign boundary_o = bnd_q;
   assign ret_o = ret_q;
   assign takes_o = take_cnt;
endmodule : core_model

// *** bench/tb_top.sv ***
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
   import intc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tmr = 1'b0, pin = 1'b1, prd = 1'b0;
   logic sleep = 1'b0, slow = 1'b1, ret = 1'b0, ack, bnd, ret_p, wake;
   logic [7:0] adr = 8'h00;
   logic [7:0] preq = 8'h00;
   logic [3:0] port = 4'h0;
   logic [31:0] dat = 32'h0;
   logic [31:0] q, rdat;
   core_req_type core_o;
   int takes, n;
   int error_cnt = 0;
   int total_checks = 0;

   always #5 clk_i = ~clk_i;

   interrupt_controller DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .timer_zero_overflow_i(tmr), .ext_pin_zero_i(pin), .port_upper_i(port), .port_read_i(prd),
      .periph_req_i(preq), .insn_boundary_i(bnd), .return_from_handler_i(ret_p), .core_asleep_i(sleep),
      .core_o(core_o), .wake_o(wake));

   core_model CPU (.clk_i(clk_i), .slow_i(slow), .ret_i(ret), .core_i(core_o), .boundary_o(bnd),
      .ret_o(ret_p), .takes_o(takes));

   // ------------------------------------------------------------
   // Bus and stimulus tasks
   // ------------------------------------------------------------
   // Request held until ack is sampled high; one idle cycle follows
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      // No cycle count assumed; only the watchdog ends a hung wait
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'h0, d});
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask : rdchk

   task automatic tick(input int c);
      repeat (c) @(posedge clk_i);
   endtask : tick

   task automatic pulse_tmr;
      tmr <= 1'b1;
      @(posedge clk_i);
      tmr <= 1'b0;
   endtask : pulse_tmr

   task automatic do_ret;
      ret <= 1'b1;
      @(posedge clk_i);
      ret <= 1'b0;
      tick(3);
   endtask : do_ret

   task automatic end_sim;
      if (error_cnt == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim

   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      error_cnt++;
      end_sim;
   end

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      tick(5);
      rst_i <= 1'b0;
      tick(1);
      rdchk(MAIN_CTL_ADDR, {24'h0, MAIN_CTL_RESET});
      rdchk(CONFIG_ADDR, 32'h0);
      rdchk(8'h40, 32'h0);
      // Compat mode, slow core: flag first, then enables
      pulse_tmr;
      rdchk(MAIN_CTL_ADDR, 32'h04);
      `CHK(takes, 0)
      wr(MAIN_CTL_ADDR, 8'ha4);
      tick(4);
      `CHK(takes, 1)
      `CHK(core_o.vector, VEC_HIGH)
      rdchk(MAIN_CTL_ADDR, 32'h24);
      wr(MAIN_CTL_ADDR, 8'h20);
      do_ret;
      rdchk(MAIN_CTL_ADDR, 32'ha0);
      // Peripheral requests need bit 6 as well
      wr(MAIN_CTL_ADDR, 8'h80);
      preq <= 8'h01;
      tick(4);
      `CHK(takes, 1)
      wr(MAIN_CTL_ADDR, 8'hc0);
      tick(4);
      `CHK(takes, 2)
      preq <= 8'h00;
      rdchk(MAIN_CTL_ADDR, 32'h40);
      do_ret;
      rdchk(MAIN_CTL_ADDR, 32'hc0);
      // Priority mode, timer on the low level, fast core
      slow <= 1'b0;
      wr(CONFIG_ADDR, 8'h80);
      wr(MAIN_CTL_ADDR, 8'h60);
      pulse_tmr;
      tick(4);
      `CHK(takes, 2)
      wr(MAIN_CTL_ADDR, 8'he4);
      tick(4);
      `CHK(takes, 3)
      `CHK(core_o.vector, VEC_LOW)
      rdchk(MAIN_CTL_ADDR, 32'ha4);
      rdchk(STATUS_ADDR, 32'h2);
      // High pin request preempts the low handler
      wr(CONFIG_ADDR, 8'h82);
      wr(MAIN_CTL_ADDR, 8'hb0);
      pin <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (core_o.take !== 1'b1 && n < 20);
      `CHK(n >= 4 && n <= 5, 1'b1)
      `CHK(core_o.vector, VEC_HIGH)
      rdchk(STATUS_ADDR, 32'h4);
      // Pending low request held off during the high handler
      pulse_tmr;
      wr(MAIN_CTL_ADDR, 8'hf4);
      tick(6);
      `CHK(takes, 4)
      `CHK(core_o.irq, 1'b0)
      wr(MAIN_CTL_ADDR, 8'h30);
      do_ret;
      rdchk(MAIN_CTL_ADDR, 32'hb0);
      do_ret;
      rdchk(MAIN_CTL_ADDR, 32'hf0);
      // Rising edge select on the pin
      wr(MAIN_CTL_ADDR, 8'h00);
      wr(CONFIG_ADDR, 8'h40);
      pin <= 1'b1;
      tick(6);
      rdchk(MAIN_CTL_ADDR, 32'h02);
      wr(MAIN_CTL_ADDR, 8'h00);
      pin <= 1'b0;
      tick(6);
      rdchk(MAIN_CTL_ADDR, 32'h00);
      // Port mismatch keeps the flag until the port is read
      port <= 4'h1;
      tick(6);
      rdchk(MAIN_CTL_ADDR, 32'h01);
      wr(MAIN_CTL_ADDR, 8'h00);
      rdchk(MAIN_CTL_ADDR, 32'h01);
      prd <= 1'b1;
      tick(1);
      prd <= 1'b0;
      wr(MAIN_CTL_ADDR, 8'h00);
      rdchk(MAIN_CTL_ADDR, 32'h00);
      // Enabled flag wakes a sleeping core without a global enable
      sleep <= 1'b1;
      pulse_tmr;
      wr(MAIN_CTL_ADDR, 8'h24);
      tick(2);
      `CHK(wake, 1'b1)
      `CHK(takes, 4)
      end_sim;
   end
endmodule : tb_top

// *** core/intc_pkg.sv ***
// Shared constants and carriers for the two-level interrupt controller
package intc_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses on the 32-bit bus)
   // ------------------------------------------------------------
   localparam logic [7:0] MAIN_CTL_ADDR = 8'h00;
   localparam logic [7:0] CONFIG_ADDR = 8'h04;
   localparam logic [7:0] STATUS_ADDR = 8'h08;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] MAIN_CTL_RESET = 8'h00;
   localparam logic [7:0] PRIO_RESET = 8'h00;

   // ------------------------------------------------------------
   // Vector addresses
   // ------------------------------------------------------------
   localparam logic [15:0] VEC_HIGH = 16'h0008;
   localparam logic [15:0] VEC_LOW = 16'h0018;

   // Main control layout, bit 7 first
   typedef struct packed {
      logic global_high_enable;
      logic peripheral_low_enable;
      logic timer_zero_overflow_en;
      logic ext_pin_zero_en;
      logic port_change_en;
      logic timer_zero_overflow_flag;
      logic ext_pin_zero_flag;
      logic port_change_flag;
   } main_ctl_type;

   // Own configuration register layout (low byte)
   typedef struct packed {
      logic priority_levels_on;
      logic ext_pin_zero_edge_sel;
      logic [2:0] unused;
      logic timer_zero_prio;
      logic ext_pin_zero_prio;
      logic port_change_prio;
   } config_type;

   // Request carried to the core
   typedef struct packed {
      logic irq;
      logic take;
      logic [15:0] vector;
   } core_req_type;

   // Handler nesting
   typedef enum logic [2:0] {
      RUN_MAIN,
      IN_COMPAT,
      IN_LOW,
      IN_HIGH,
      IN_HIGH_OVER_LOW
   } handler_state_type;

endpackage : intc_pkg

// *** core/interrupt_controller.sv ***
// Two-level interrupt controller with classic Wishbone register access
`timescale 1ns/1ps
module interrupt_controller
   import intc_pkg::*;
#(
   parameter int PERIPH_N = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic timer_zero_overflow_i,
   input wire logic ext_pin_zero_i,
   input wire logic [3:0] port_upper_i,
   input wire logic port_read_i,
   input wire logic [PERIPH_N-1:0] periph_req_i,
   input wire logic insn_boundary_i,
   input wire logic return_from_handler_i,
   input wire logic core_asleep_i,
   output core_req_type core_o,
   output logic wake_o
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   main_ctl_type ctl, next_ctl;
   config_type cfg, next_cfg;
   logic [PERIPH_N-1:0] periph_prio, next_periph_prio;
   handler_state_type state, next_state;
   core_req_type core_q, next_core;
   logic wake, next_wake;
   logic ack, next_ack;
   logic [31:0] rdata, next_rdata;
   logic [1:0] pin_sync, next_pin_sync;
   logic pin_prev, next_pin_prev;
   logic [3:0] port_s1, port_s2, port_snap;
   logic [3:0] next_port_s1, next_port_s2, next_port_snap;

   // ------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------
   logic wb_req, wr_main, wr_cfg;
   logic pin_edge, port_mismatch;
   logic [2:0] core_flags, core_en, core_prio;
   logic src_high, src_low, periph_any, periph_high, periph_low;
   logic hi_take, lo_take, compat_take, take_now;

   // Byte-lane aware write of one byte
   function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d, input logic [3:0] sel);
      lane0 = sel[0] ? d[7:0] : old;
   endfunction : lane0

   assign wb_req = wb_cyc_i && wb_stb_i && !ack;
   assign wr_main = wb_req && wb_we_i && (wb_adr_i == MAIN_CTL_ADDR);
   assign wr_cfg = wb_req && wb_we_i && (wb_adr_i == CONFIG_ADDR);

   // Edge of the synchronised pin, polarity by select bit
   assign pin_edge = cfg.ext_pin_zero_edge_sel ? (pin_sync[1] && !pin_prev)
                                               : (!pin_sync[1] && pin_prev);
   // Mismatch holds until a port read refreshes the snapshot
   assign port_mismatch = (port_s2 != port_snap);

   // Per-source flag, enable and priority, timer/pin/port order
   assign core_flags = {ctl.timer_zero_overflow_flag, ctl.ext_pin_zero_flag, ctl.port_change_flag};
   assign core_en = {ctl.timer_zero_overflow_en, ctl.ext_pin_zero_en, ctl.port_change_en};
   assign core_prio = {cfg.timer_zero_prio, cfg.ext_pin_zero_prio, cfg.port_change_prio};
   assign periph_any = |periph_req_i;
   assign periph_high = |(periph_req_i & periph_prio);
   assign periph_low = |(periph_req_i & ~periph_prio);
   assign src_high = |(core_flags & core_en & core_prio) || periph_high;
   assign src_low = |(core_flags & core_en & ~core_prio) || periph_low;

   // Acceptance conditions per mode
   always_comb begin
      hi_take = 1'b0;
      lo_take = 1'b0;
      compat_take = 1'b0;
      if (cfg.priority_levels_on) begin
         // High level needs only bit 7; low needs both bits 7 and 6
         hi_take = ctl.global_high_enable && src_high
                   && state != IN_HIGH && state != IN_HIGH_OVER_LOW;
         lo_take = ctl.global_high_enable && ctl.peripheral_low_enable && src_low
                   && state == RUN_MAIN && !hi_take;
      end else begin
         // Priority bits are ignored here
         compat_take = ctl.global_high_enable
                       && (|(core_flags & core_en) || (ctl.peripheral_low_enable && periph_any));
      end
   end
   assign take_now = insn_boundary_i && (hi_take || lo_take || compat_take);

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      next_ctl = ctl;
      next_cfg = cfg;
      next_periph_prio = periph_prio;
      next_state = state;
      next_core = core_q;
      next_ack = wb_req;
      next_rdata = 32'h0000_0000;
      next_pin_sync = {pin_sync[0], ext_pin_zero_i};
      next_pin_prev = pin_sync[1];
      next_port_s1 = port_upper_i;
      next_port_s2 = port_s1;
      next_port_snap = port_read_i ? port_s2 : port_snap;
      // Software writes first, hardware effects override
      if (wr_main) begin
         next_ctl = main_ctl_type'(lane0(ctl, wb_dat_i, wb_sel_i));
      end
      if (wr_cfg) begin
         next_cfg = config_type'(lane0(cfg, wb_dat_i, wb_sel_i));
         if (wb_sel_i[1]) begin
            next_periph_prio = wb_dat_i[8 +: PERIPH_N];
         end
      end
      // Return restores the enable cleared by the matching acceptance
      if (return_from_handler_i) begin
         case (state)
            IN_COMPAT: begin
               next_ctl.global_high_enable = 1'b1;
               next_state = RUN_MAIN;
            end
            IN_LOW: begin
               next_ctl.peripheral_low_enable = 1'b1;
               next_state = RUN_MAIN;
            end
            IN_HIGH: begin
               next_ctl.global_high_enable = 1'b1;
               next_state = RUN_MAIN;
            end
            IN_HIGH_OVER_LOW: begin
               next_ctl.global_high_enable = 1'b1;
               next_state = IN_LOW;
            end
            default: begin
               next_state = RUN_MAIN;
            end
         endcase
      end
      // Acceptance: clear the level enable and hand the vector to the core
      next_core.take = take_now;
      if (take_now) begin
         if (hi_take) begin
            next_ctl.global_high_enable = 1'b0;
            next_core.vector = VEC_HIGH;
            next_state = (state == IN_LOW) ? IN_HIGH_OVER_LOW : IN_HIGH;
         end else if (lo_take) begin
            next_ctl.peripheral_low_enable = 1'b0;
            next_core.vector = VEC_LOW;
            next_state = IN_LOW;
         end else begin
            next_ctl.global_high_enable = 1'b0;
            next_core.vector = VEC_HIGH;
            next_state = IN_COMPAT;
         end
      end
      next_core.irq = hi_take || lo_take || compat_take;
      // Event sets win over a same-cycle software clear
      if (timer_zero_overflow_i) begin
         next_ctl.timer_zero_overflow_flag = 1'b1;
      end
      if (pin_edge) begin
         next_ctl.ext_pin_zero_flag = 1'b1;
      end
      if (port_mismatch) begin
         next_ctl.port_change_flag = 1'b1;
      end
      next_wake = core_asleep_i && (|(next_ctl[2:0] & core_en) || periph_any);
      // Read data; unmapped addresses answer zero
      if (wb_req && !wb_we_i) begin
         case (wb_adr_i)
            MAIN_CTL_ADDR: next_rdata = {24'h00_0000, ctl};
            CONFIG_ADDR: next_rdata = 32'(cfg) | (32'(periph_prio) << 8);
            STATUS_ADDR: next_rdata = {20'h0_0000, port_snap, 5'h00, state};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Port-change flag has no defined power-up value; zero is used
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl <= main_ctl_type'(MAIN_CTL_RESET);
         cfg <= config_type'(PRIO_RESET);
         periph_prio <= '0;
         state <= RUN_MAIN;
         core_q <= '0;
         wake <= 1'b0;
         ack <= 1'b0;
         rdata <= 32'h0000_0000;
         pin_sync <= 2'h0;
         pin_prev <= 1'b0;
         port_s1 <= 4'h0;
         port_s2 <= 4'h0;
         port_snap <= 4'h0;
      end else if (ce_i) begin
         ctl <= next_ctl;
         cfg <= next_cfg;
         periph_prio <= next_periph_prio;
         state <= next_state;
         core_q <= next_core;
         wake <= next_wake;
         ack <= next_ack;
         rdata <= next_rdata;
         pin_sync <= next_pin_sync;
         pin_prev <= next_pin_prev;
         port_s1 <= next_port_s1;
         port_s2 <= next_port_s2;
         port_snap <= next_port_snap;
      end
   end

   assign core_o = core_q;
   assign wake_o = wake;
   assign wb_ack_o = ack;
   assign wb_dat_o = rdata;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   // Checks watch registered outputs one edge after the cause (the pin latency check three edges, the ack check one and two), so glitches do not count
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Vector and level selection
   a_compat_vector_fixed: assert property (ce_i && take_now && !cfg.priority_levels_on
      |=> core_o.take && core_o.vector == VEC_HIGH) else $error("compat vector wrong");
   a_low_vector_sel: assert property (ce_i && take_now && lo_take
      |=> core_o.vector == VEC_LOW && !ctl.peripheral_low_enable) else $error("low vector wrong");
   a_high_vector_sel: assert property (ce_i && take_now && hi_take
      |=> core_o.take && core_o.vector == VEC_HIGH) else $error("high vector wrong");
   a_high_preempts_low: assert property (ce_i && state == IN_LOW && cfg.priority_levels_on
      && insn_boundary_i && ctl.global_high_enable && src_high |=> core_o.take && core_o.vector == VEC_HIGH
      && state == IN_HIGH_OVER_LOW) else $error("high did not preempt");
   // Gating by the two global enables and by handler nesting
   a_no_low_in_high: assert property (ce_i && (state == IN_HIGH || state == IN_HIGH_OVER_LOW)
      |=> !(core_o.take && core_o.vector == VEC_LOW)) else $error("low taken inside high handler");
   a_gie_off_blocks: assert property (ce_i && !ctl.global_high_enable
      |=> !core_o.take) else $error("take with bit 7 clear");
   a_low_needs_level: assert property (ce_i && cfg.priority_levels_on
      && !ctl.peripheral_low_enable && !src_high
      |=> !core_o.take) else $error("low take with bit 6 clear");
   a_compat_periph_gate: assert property (ce_i && !cfg.priority_levels_on && !ctl.peripheral_low_enable
      && !(|(core_flags & core_en)) |=> !core_o.take) else $error("peripheral taken with bit 6 clear");
   // Enable bookkeeping on accept and return
   a_accept_clears_enable: assert property (ce_i && take_now && !lo_take
      |=> !ctl.global_high_enable) else $error("enable not cleared");
   a_return_reenables: assert property (ce_i && return_from_handler_i && state == IN_COMPAT && !take_now
      |=> ctl.global_high_enable && state == RUN_MAIN) else $error("return did not re-enable");
   // Flags and wake-up
   a_timer_flag_sticky: assert property (ce_i && timer_zero_overflow_i
      |=> ctl.timer_zero_overflow_flag) else $error("timer flag lost");
   a_pin_flag_set: assert property (ce_i && pin_edge
      |=> ctl.ext_pin_zero_flag) else $error("pin flag lost");
   a_port_flag_set: assert property (ce_i && port_mismatch
      |=> ctl.port_change_flag) else $error("port flag lost");
   a_pin_flag_latency: assert property (ce_i [*4] ##0 cfg.ext_pin_zero_edge_sel && $rose(ext_pin_zero_i)
      && $stable(cfg) ##1 ce_i [*3] |-> ctl.ext_pin_zero_flag) else $error("pin flag late");
   a_wake_follows: assert property (ce_i && core_asleep_i && |(ctl[2:0] & core_en) && !wr_main
      |=> wake_o) else $error("no wake for enabled flag");
   // Bus handshake
   a_wb_ack_single: assert property (ce_i && wb_req |=> wb_ack_o ##1 !wb_ack_o || !ce_i)
      else $error("ack not single cycle");

   c_compat_take: cover property (core_o.take && !cfg.priority_levels_on);
   c_low_take: cover property (core_o.take && core_o.vector == 16'h0018);
   c_nested_high: cover property (state == IN_HIGH_OVER_LOW);
   c_wake: cover property (wake_o);

endmodule : interrupt_controller
